// >>> handshake_port_pkg.sv
package handshake_port_pkg;

  // ****************************************
  // Host addresses
  // ****************************************
  localparam logic [1:0] ADDR_PORT_A = 2'h0;
  localparam logic [1:0] ADDR_PORT_B = 2'h1;
  localparam logic [1:0] ADDR_PORT_C = 2'h2;
  localparam logic [1:0] ADDR_CONTROL = 2'h3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] CONTROL_RESET = 8'h9B;
  localparam logic [7:0] PORT_RESET = 8'h00;

  // ****************************************
  // Control word fields
  // ****************************************
  localparam int CW_MODE_FLAG = 7;
  localparam int CW_A_BIDIR = 6;
  localparam int CW_A_STROBED = 5;
  localparam int CW_A_DIR_IN = 4;
  localparam int CW_CU_DIR_IN = 3;
  localparam int CW_B_STROBED = 2;
  localparam int CW_B_DIR_IN = 1;
  localparam int CW_CL_DIR_IN = 0;

  // ****************************************
  // Single-bit set/reset fields
  // ****************************************
  localparam int BSR_SEL_HI = 3;
  localparam int BSR_SEL_LO = 1;
  localparam int BSR_VALUE = 0;

  // ****************************************
  // Handshake status word bit positions
  // ****************************************
  localparam int PC_B_REQ = 0;
  localparam int PC_B_FULL = 1;
  localparam int PC_B_HS = 2;
  localparam int PC_A_REQ = 3;
  localparam int PC_A_STB = 4;
  localparam int PC_A_IN_FULL = 5;
  localparam int PC_A_ACK = 6;
  localparam int PC_A_OUT_FULL = 7;

endpackage

// >>> handshake_channel.sv
`timescale 1ns/1ns
module handshake_channel (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Configuration
  input wire logic clear_i,
  input wire logic in_side_i,
  input wire logic out_side_i,
  input wire logic in_enable_i,
  input wire logic out_enable_i,
  // Peripheral strobes
  input wire logic load_strobe_n_i,
  input wire logic accept_n_i,
  // Host activity on this port
  input wire logic read_active_i,
  input wire logic read_rise_i,
  input wire logic write_active_i,
  input wire logic write_rise_i,
  // Bit set/reset of the full flags
  input wire logic in_full_wr_i,
  input wire logic out_full_wr_i,
  input wire logic bsr_value_i,
  // Status
  output logic input_full_o,
  output logic output_full_n_o,
  output logic service_request_o
);

  logic input_full_reg, input_full_next;
  logic output_full_n_reg, output_full_n_next;
  logic service_request_reg, service_request_next;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    input_full_next = input_full_reg;
    if (clear_i || !in_side_i) begin
      input_full_next = 1'b0;
    end else if (!load_strobe_n_i) begin
      input_full_next = 1'b1;
    end else if (in_full_wr_i) begin
      input_full_next = bsr_value_i;
    end else if (read_rise_i) begin
      input_full_next = 1'b0;
    end
    output_full_n_next = output_full_n_reg;
    if (clear_i || !out_side_i) begin
      output_full_n_next = 1'b1;
    end else if (write_rise_i) begin
      output_full_n_next = 1'b0;
    end else if (out_full_wr_i) begin
      output_full_n_next = bsr_value_i;
    end else if (!accept_n_i) begin
      output_full_n_next = 1'b1;
    end
    service_request_next = !clear_i &&
      ((in_side_i && input_full_reg && input_full_next && in_enable_i
        && load_strobe_n_i && !read_active_i) ||
       (out_side_i && output_full_n_reg && output_full_n_next && out_enable_i
        && accept_n_i && !write_active_i));
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      input_full_reg <= 1'b0;
      output_full_n_reg <= 1'b1;
      service_request_reg <= 1'b0;
    end else begin
      input_full_reg <= input_full_next;
      output_full_n_reg <= output_full_n_next;
      service_request_reg <= service_request_next;
    end
  end

  assign input_full_o = input_full_reg;
  assign output_full_n_o = output_full_n_reg;
  assign service_request_o = service_request_reg;

endmodule

// >>> strobed_handshake_port.sv
`timescale 1ns/1ns
// Summary of operation
// - Strobed mode uses port C lines as handshake for ports A and B.
// - Strobed data ports are input or output, latched both ways.
// - Low load strobe captures port data into the input latch.
// - Input full sets on low strobe, clears on host read rising edge.
// - Input request when strobe high, full and enabled; read falling clears.
// - Input enables: group A via bit 4, group B via bit 2.
// - Output full goes low on write rising edge, high on accept low.
// - Output request when accept high, full high, enabled; write clears.
// - Output enables: group A via bit 6, group B via bit 2.
// - Bidirectional mode is group A only, five control lines, latched.
// - Bidirectional host write to port A drives output full low.
// - Bidirectional port A drivers enabled only while accept is low.
// - Bidirectional request is the OR of input and output conditions.
// - Port C read shows live lines, enables replace strobe/accept bits.
// - Plain port C write reaches only basic-mode output pins.
// - Bit set/reset writes any port C output except request bits 0 and 3, inputs untouched.
// - Bit set/reset on strobe/accept positions changes the enable flag.
// - Unused port C lines are plain inputs or outputs per mode word.
// - Enable flags clear on mode selection and reset.
// - Mode change clears all output registers and status flip-flops.
// - Group A output enable sits at bit 6 in both strobed modes.
module strobed_handshake_port (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Host bus
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // Port A
  input wire logic [7:0] pa_i,
  output logic [7:0] pa_o,
  output logic pa_oe_o,
  // Port B
  input wire logic [7:0] pb_i,
  output logic [7:0] pb_o,
  output logic pb_oe_o,
  // Port C
  input wire logic [7:0] pc_i,
  output logic [7:0] pc_o,
  output logic [7:0] pc_oe_o
);

  // ****************************************
  // Host access tracking
  // ****************************************
  logic [3:0] rd_hit, wr_hit;
  logic [3:0] rd_hit_reg, wr_hit_reg;
  logic [3:0] rd_rise, wr_done;
  logic [7:0] wdata_reg, wdata_next;
  logic [7:0] data_o_reg, data_o_next;
  logic data_oe_reg, data_oe_next;

  always_comb begin
    rd_hit = 4'h0;
    wr_hit = 4'h0;
    if (!cs_n_i && !rd_n_i) begin
      rd_hit[addr_i] = 1'b1;
    end
    if (!cs_n_i && !wr_n_i) begin
      wr_hit[addr_i] = 1'b1;
    end
    rd_rise = rd_hit_reg & ~rd_hit;
    wr_done = wr_hit_reg & ~wr_hit;
    wdata_next = (|wr_hit) ? data_i : wdata_reg;
  end

  // ****************************************
  // Mode decode
  // ****************************************
  logic [7:0] control_reg, control_next;
  logic a_bidir, a_strobed, a_in, b_strobed, b_in;
  logic a_hs_in, a_hs_out, b_hs_in, b_hs_out;
  logic mode_write, bsr_write, bsr_value;
  logic [7:0] bsr_hit;

  always_comb begin
    a_bidir = control_reg[handshake_port_pkg::CW_A_BIDIR];
    a_strobed = !a_bidir && control_reg[handshake_port_pkg::CW_A_STROBED];
    a_in = control_reg[handshake_port_pkg::CW_A_DIR_IN];
    b_strobed = control_reg[handshake_port_pkg::CW_B_STROBED];
    b_in = control_reg[handshake_port_pkg::CW_B_DIR_IN];
    a_hs_in = (a_strobed && a_in) || a_bidir;
    a_hs_out = (a_strobed && !a_in) || a_bidir;
    b_hs_in = b_strobed && b_in;
    b_hs_out = b_strobed && !b_in;
    mode_write = wr_done[handshake_port_pkg::ADDR_CONTROL]
      && wdata_reg[handshake_port_pkg::CW_MODE_FLAG];
    bsr_write = wr_done[handshake_port_pkg::ADDR_CONTROL]
      && !wdata_reg[handshake_port_pkg::CW_MODE_FLAG];
    bsr_value = wdata_reg[handshake_port_pkg::BSR_VALUE];
    bsr_hit = 8'h00;
    if (bsr_write) begin
      bsr_hit[wdata_reg[handshake_port_pkg::BSR_SEL_HI:handshake_port_pkg::BSR_SEL_LO]] = 1'b1;
    end
    control_next = mode_write ? wdata_reg : control_reg;
  end

  // ****************************************
  // Port C line roles
  // ****************************************
  logic [7:0] hs_out_mask, hs_in_mask, plain_out_mask;

  always_comb begin
    hs_out_mask = 8'h00;
    hs_in_mask = 8'h00;
    if (b_strobed) begin
      hs_out_mask[handshake_port_pkg::PC_B_REQ] = 1'b1;
      hs_out_mask[handshake_port_pkg::PC_B_FULL] = 1'b1;
      hs_in_mask[handshake_port_pkg::PC_B_HS] = 1'b1;
    end
    if (a_hs_in || a_hs_out) begin
      hs_out_mask[handshake_port_pkg::PC_A_REQ] = 1'b1;
    end
    if (a_hs_in) begin
      hs_in_mask[handshake_port_pkg::PC_A_STB] = 1'b1;
      hs_out_mask[handshake_port_pkg::PC_A_IN_FULL] = 1'b1;
    end
    if (a_hs_out) begin
      hs_in_mask[handshake_port_pkg::PC_A_ACK] = 1'b1;
      hs_out_mask[handshake_port_pkg::PC_A_OUT_FULL] = 1'b1;
    end
    plain_out_mask = {{4{!control_reg[handshake_port_pkg::CW_CU_DIR_IN]}},
                      {4{!control_reg[handshake_port_pkg::CW_CL_DIR_IN]}}}
                     & ~(hs_out_mask | hs_in_mask);
  end

  // ****************************************
  // Handshake channels
  // ****************************************
  logic a_in_full, a_out_full_n, a_req;
  logic b_in_full, b_out_full_n, b_req;
  logic b_enable_reg, b_enable_next;
  logic a_in_enable_reg, a_in_enable_next;
  logic a_out_enable_reg, a_out_enable_next;

  handshake_channel u_group_a (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .clear_i(mode_write),
    .in_side_i(a_hs_in),
    .out_side_i(a_hs_out),
    .in_enable_i(a_in_enable_reg),
    .out_enable_i(a_out_enable_reg),
    .load_strobe_n_i(pc_i[handshake_port_pkg::PC_A_STB]),
    .accept_n_i(pc_i[handshake_port_pkg::PC_A_ACK]),
    .read_active_i(rd_hit[handshake_port_pkg::ADDR_PORT_A]),
    .read_rise_i(rd_rise[handshake_port_pkg::ADDR_PORT_A]),
    .write_active_i(wr_hit[handshake_port_pkg::ADDR_PORT_A]),
    .write_rise_i(wr_done[handshake_port_pkg::ADDR_PORT_A]),
    .in_full_wr_i(bsr_hit[handshake_port_pkg::PC_A_IN_FULL]),
    .out_full_wr_i(bsr_hit[handshake_port_pkg::PC_A_OUT_FULL]),
    .bsr_value_i(bsr_value),
    .input_full_o(a_in_full),
    .output_full_n_o(a_out_full_n),
    .service_request_o(a_req)
  );

  handshake_channel u_group_b (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .clear_i(mode_write),
    .in_side_i(b_hs_in),
    .out_side_i(b_hs_out),
    .in_enable_i(b_enable_reg),
    .out_enable_i(b_enable_reg),
    .load_strobe_n_i(pc_i[handshake_port_pkg::PC_B_HS]),
    .accept_n_i(pc_i[handshake_port_pkg::PC_B_HS]),
    .read_active_i(rd_hit[handshake_port_pkg::ADDR_PORT_B]),
    .read_rise_i(rd_rise[handshake_port_pkg::ADDR_PORT_B]),
    .write_active_i(wr_hit[handshake_port_pkg::ADDR_PORT_B]),
    .write_rise_i(wr_done[handshake_port_pkg::ADDR_PORT_B]),
    .in_full_wr_i(bsr_hit[handshake_port_pkg::PC_B_FULL] && b_hs_in),
    .out_full_wr_i(bsr_hit[handshake_port_pkg::PC_B_FULL] && b_hs_out),
    .bsr_value_i(bsr_value),
    .input_full_o(b_in_full),
    .output_full_n_o(b_out_full_n),
    .service_request_o(b_req)
  );

  // ****************************************
  // Enable flags and port latches
  // ****************************************
  logic [7:0] pa_out_reg, pa_out_next, pb_out_reg, pb_out_next;
  logic [7:0] pc_out_reg, pc_out_next;
  logic [7:0] pa_in_reg, pa_in_next, pb_in_reg, pb_in_next;

  always_comb begin
    b_enable_next = b_enable_reg;
    a_in_enable_next = a_in_enable_reg;
    a_out_enable_next = a_out_enable_reg;
    pa_out_next = pa_out_reg;
    pb_out_next = pb_out_reg;
    pc_out_next = pc_out_reg;
    pa_in_next = pa_in_reg;
    pb_in_next = pb_in_reg;
    if (mode_write) begin
      b_enable_next = 1'b0;
      a_in_enable_next = 1'b0;
      a_out_enable_next = 1'b0;
      pa_out_next = handshake_port_pkg::PORT_RESET;
      pb_out_next = handshake_port_pkg::PORT_RESET;
      pc_out_next = handshake_port_pkg::PORT_RESET;
      pa_in_next = handshake_port_pkg::PORT_RESET;
      pb_in_next = handshake_port_pkg::PORT_RESET;
    end else begin
      if (bsr_hit[handshake_port_pkg::PC_B_HS] && b_strobed) begin
        b_enable_next = bsr_value;
      end
      if (bsr_hit[handshake_port_pkg::PC_A_STB] && a_hs_in) begin
        a_in_enable_next = bsr_value;
      end
      if (bsr_hit[handshake_port_pkg::PC_A_ACK] && a_hs_out) begin
        a_out_enable_next = bsr_value;
      end
      if (wr_done[handshake_port_pkg::ADDR_PORT_A] && (!a_in || a_bidir)) begin
        pa_out_next = wdata_reg;
      end
      if (wr_done[handshake_port_pkg::ADDR_PORT_B] && !b_in) begin
        pb_out_next = wdata_reg;
      end
      if (wr_done[handshake_port_pkg::ADDR_PORT_C]) begin
        pc_out_next = (pc_out_reg & ~plain_out_mask)
                      | (wdata_reg & plain_out_mask);
      end
      pc_out_next = (pc_out_next & ~(bsr_hit & plain_out_mask))
                    | ({8{bsr_value}} & bsr_hit & plain_out_mask);
      if (a_hs_in && !pc_i[handshake_port_pkg::PC_A_STB]) begin
        pa_in_next = pa_i;
      end
      if (b_hs_in && !pc_i[handshake_port_pkg::PC_B_HS]) begin
        pb_in_next = pb_i;
      end
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  logic [7:0] pc_live, status_word;

  always_comb begin
    pc_o = pc_out_reg;
    pc_o[handshake_port_pkg::PC_B_REQ] = b_strobed ? b_req
      : pc_out_reg[handshake_port_pkg::PC_B_REQ];
    pc_o[handshake_port_pkg::PC_B_FULL] = b_hs_in ? b_in_full
      : (b_hs_out ? b_out_full_n : pc_out_reg[handshake_port_pkg::PC_B_FULL]);
    pc_o[handshake_port_pkg::PC_A_REQ] = (a_hs_in || a_hs_out) ? a_req
      : pc_out_reg[handshake_port_pkg::PC_A_REQ];
    pc_o[handshake_port_pkg::PC_A_IN_FULL] = a_hs_in ? a_in_full
      : pc_out_reg[handshake_port_pkg::PC_A_IN_FULL];
    pc_o[handshake_port_pkg::PC_A_OUT_FULL] = a_hs_out ? a_out_full_n
      : pc_out_reg[handshake_port_pkg::PC_A_OUT_FULL];
    pc_oe_o = hs_out_mask | plain_out_mask;
    pa_o = pa_out_reg;
    pa_oe_o = a_bidir ? !pc_i[handshake_port_pkg::PC_A_ACK] : !a_in;
    pb_o = pb_out_reg;
    pb_oe_o = !b_in;
    pc_live = (pc_i & ~pc_oe_o) | (pc_o & pc_oe_o);
    status_word = pc_live;
    if (hs_in_mask[handshake_port_pkg::PC_B_HS]) begin
      status_word[handshake_port_pkg::PC_B_HS] = b_enable_reg;
    end
    if (hs_in_mask[handshake_port_pkg::PC_A_STB]) begin
      status_word[handshake_port_pkg::PC_A_STB] = a_in_enable_reg;
    end
    if (hs_in_mask[handshake_port_pkg::PC_A_ACK]) begin
      status_word[handshake_port_pkg::PC_A_ACK] = a_out_enable_reg;
    end
  end

  // ****************************************
  // Host read data
  // ****************************************
  always_comb begin
    data_oe_next = |rd_hit;
    data_o_next = data_o_reg;
    unique case (addr_i)
      handshake_port_pkg::ADDR_PORT_A: begin
        data_o_next = a_hs_in ? pa_in_reg : (a_in ? pa_i : pa_out_reg);
      end
      handshake_port_pkg::ADDR_PORT_B: begin
        data_o_next = b_hs_in ? pb_in_reg : (b_in ? pb_i : pb_out_reg);
      end
      handshake_port_pkg::ADDR_PORT_C: begin
        data_o_next = status_word;
      end
      handshake_port_pkg::ADDR_CONTROL: begin
        data_o_next = control_reg;
      end
    endcase
    if (!data_oe_next) begin
      data_o_next = data_o_reg;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_hit_reg <= 4'h0;
      wr_hit_reg <= 4'h0;
      wdata_reg <= 8'h00;
      data_o_reg <= 8'h00;
      data_oe_reg <= 1'b0;
      control_reg <= handshake_port_pkg::CONTROL_RESET;
      b_enable_reg <= 1'b0;
      a_in_enable_reg <= 1'b0;
      a_out_enable_reg <= 1'b0;
      pa_out_reg <= handshake_port_pkg::PORT_RESET;
      pb_out_reg <= handshake_port_pkg::PORT_RESET;
      pc_out_reg <= handshake_port_pkg::PORT_RESET;
      pa_in_reg <= handshake_port_pkg::PORT_RESET;
      pb_in_reg <= handshake_port_pkg::PORT_RESET;
    end else begin
      rd_hit_reg <= rd_hit;
      wr_hit_reg <= wr_hit;
      wdata_reg <= wdata_next;
      data_o_reg <= data_o_next;
      data_oe_reg <= data_oe_next;
      control_reg <= control_next;
      b_enable_reg <= b_enable_next;
      a_in_enable_reg <= a_in_enable_next;
      a_out_enable_reg <= a_out_enable_next;
      pa_out_reg <= pa_out_next;
      pb_out_reg <= pb_out_next;
      pc_out_reg <= pc_out_next;
      pa_in_reg <= pa_in_next;
      pb_in_reg <= pb_in_next;
    end
  end

  assign data_o = data_o_reg;
  assign data_oe_o = data_oe_reg;

endmodule

// >>> strobed_handshake_port_chk.sv
`timescale 1ns/1ns
module strobed_handshake_port_chk (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Host bus
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic data_oe_o,
  // Ports
  input wire logic pa_oe_o,
  input wire logic pb_oe_o,
  input wire logic [7:0] pc_i,
  input wire logic [7:0] pc_o,
  input wire logic [7:0] pc_oe_o
);
  // ****************************************
  // Mode tracking
  // ****************************************
  logic wr_reg, wr_next, rda_reg, rda_next;
  logic [1:0] addr_reg, addr_next, age_reg, age_next;
  logic [7:0] data_reg, data_next, mode_reg, mode_next;
  logic wr_act, rd_act, rda, commit, a_in, b_out, settled;
  assign wr_act = !cs_n_i && !wr_n_i;
  assign rd_act = !cs_n_i && !rd_n_i;
  assign rda = rd_act && addr_i == handshake_port_pkg::ADDR_PORT_A;
  assign commit = wr_reg && !wr_act;
  assign settled = age_reg == 2'h3;
  assign a_in = settled && mode_reg[6:4] == 3'h3;
  assign b_out = settled && mode_reg[2:1] == 2'h2;
  always_comb begin
    wr_next = wr_act;
    rda_next = rda;
    addr_next = wr_act ? addr_i : addr_reg;
    data_next = wr_act ? data_i : data_reg;
    mode_next = mode_reg;
    age_next = settled ? age_reg : age_reg + 2'h1;
    if (commit && addr_reg == handshake_port_pkg::ADDR_CONTROL && data_reg[7]) begin
      mode_next = data_reg;
      age_next = 2'h0;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_reg <= 1'b0;
      rda_reg <= 1'b0;
      addr_reg <= 2'h0;
      data_reg <= 8'h00;
      mode_reg <= handshake_port_pkg::CONTROL_RESET;
      age_reg <= 2'h3;
    end else begin
      wr_reg <= wr_next;
      rda_reg <= rda_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      mode_reg <= mode_next;
      age_reg <= age_next;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence rd_a_end;
    rda_reg && !rda && pc_i[4];
  endsequence
  sequence wr_b_commit;
    commit && addr_reg == handshake_port_pkg::ADDR_PORT_B;
  endsequence
  read_enable_a: assert property (rd_act |=> data_oe_o)
    else $error("read enable missing");
  reset_idle_a: assert property (settled && mode_reg == 8'h9B |-> pc_oe_o == 8'h00 && !pa_oe_o)
    else $error("drivers on in reset mode");
  port_b_dir_a: assert property (settled |-> pb_oe_o == !mode_reg[1])
    else $error("port b direction wrong");
  bidir_drive_a: assert property (settled && mode_reg[6] |-> pa_oe_o == !pc_i[6])
    else $error("bidir drive enable wrong");
  in_full_set_a: assert property (a_in && !pc_i[4] |=> pc_o[5])
    else $error("input full not set");
  in_full_clr_a: assert property ((a_in and rd_a_end) |-> ##[1:2] !pc_o[5])
    else $error("input full not cleared");
  in_req_rise_a: assert property (a_in && $rose(pc_o[3]) |-> $past(pc_o[5]) && $past(pc_i[4]))
    else $error("input request without cause");
  rd_clear_a: assert property (a_in && rda |=> !pc_o[3])
    else $error("input request during read");
  out_full_set_a: assert property ((b_out and wr_b_commit) |-> ##[1:2] !pc_o[1])
    else $error("output full not driven low");
  out_full_clr_a: assert property (b_out && !pc_i[2] && !wr_act && !wr_reg |-> ##[1:2] pc_o[1])
    else $error("output full not released");
  out_req_rise_a: assert property (b_out && $rose(pc_o[0]) |-> $past(pc_o[1]) && $past(pc_i[2]))
    else $error("output request without cause");
  wr_clear_a: assert property (b_out && wr_act && addr_i == 2'h1 |=> !pc_o[0])
    else $error("output request during write");
endmodule

// >>> peripheral_model.sv
`timescale 1ns/1ns
module peripheral_model (
  // Clock
  input wire logic clk_sys_i,
  // Lines seen from the port
  input wire logic [7:0] pc_line_i,
  input wire logic [7:0] pb_line_i,
  // Lines driven toward the port, and data taken from port B
  output logic [7:0] pa_drv_o,
  output logic [7:0] pc_drv_o,
  output logic [7:0] taken_o
);
  // ****************************************
  // Peripheral behaviour
  // ****************************************
  logic full_q;
  initial begin
    pa_drv_o = 8'h00;
    pc_drv_o = 8'hFF;
    taken_o = 8'h00;
    full_q = 1'b1;
  end
  always @(posedge clk_sys_i) begin
    if (!full_q && pc_line_i[1]) begin
      taken_o <= pb_line_i;
    end
    full_q <= pc_line_i[1];
  end
  task automatic pin(input int idx, input logic v);
    @(posedge clk_sys_i);
    pc_drv_o[idx] <= v;
    @(negedge clk_sys_i);
  endtask
  task automatic load_a(input logic [7:0] d);
    @(posedge clk_sys_i);
    pa_drv_o <= d;
    pc_drv_o[4] <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    pc_drv_o[4] <= 1'b1;
    pa_drv_o <= ~d;
    @(negedge clk_sys_i);
  endtask
  task automatic accept_b(input int slow, output logic ok);
    int i;
    ok = 1'b0;
    repeat (slow) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    pc_drv_o[2] <= 1'b0;
    for (i = 0; i < 20 && !ok; i++) begin
      @(negedge clk_sys_i);
      ok = pc_line_i[1];
    end
    @(posedge clk_sys_i);
    pc_drv_o[2] <= 1'b1;
    @(negedge clk_sys_i);
  endtask
endmodule

// >>> strobed_handshake_port_bench.sv
`timescale 1ns/1ns
module strobed_handshake_port_bench;
  // ****************************************
  // Signals and helpers
  // ****************************************
  logic clk_sys_i, rst_n_i, cs_n_i, rd_n_i, wr_n_i, data_oe_o, pa_oe_o, pb_oe_o, ok;
  logic [1:0] addr_i;
  logic [7:0] data_i, data_o, pa_i, pa_o, pb_i, pb_o, pc_i, pc_o, pc_oe_o;
  logic [7:0] pa_drv, pc_drv, taken, r, d;
  int n_mismatch, checks, i;
  assign pc_i = (pc_oe_o & pc_o) | (~pc_oe_o & pc_drv);
  assign pa_i = pa_oe_o ? pa_o : pa_drv;
  assign pb_i = ~pb_o;
  strobed_handshake_port i_strobed_handshake_port (.clk_sys_i, .rst_n_i, .cs_n_i, .rd_n_i,
    .wr_n_i, .addr_i, .data_i, .data_o, .data_oe_o, .pa_i, .pa_o, .pa_oe_o, .pb_i, .pb_o,
    .pb_oe_o, .pc_i, .pc_o, .pc_oe_o);
  peripheral_model i_peripheral_model (.clk_sys_i, .pc_line_i(pc_i), .pb_line_i(pb_o),
    .pa_drv_o(pa_drv), .pc_drv_o(pc_drv), .taken_o(taken));
  function automatic logic [7:0] status(input logic [1:0] plain, input logic full_a,
    input logic en_a, input logic en_b, input logic full_n_b);
    return {plain, full_a, en_a, full_a & en_a, en_b, full_n_b, full_n_b & en_b};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    cs_n_i <= 1'b0;
    wr_n_i <= 1'b0;
    addr_i <= a;
    data_i <= v;
    @(posedge clk_sys_i);
    cs_n_i <= 1'b1;
    wr_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    cs_n_i <= 1'b0;
    rd_n_i <= 1'b0;
    addr_i <= a;
    @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    v = data_o;
    check("read enable", 8'(data_oe_o), 8'h01);
    @(posedge clk_sys_i);
    cs_n_i <= 1'b1;
    rd_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  // ****************************************
  // Clock, watchdog and sequence
  // ****************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    close_out();
  end
  initial begin
    rst_n_i = 1'b0;
    cs_n_i = 1'b1;
    rd_n_i = 1'b1;
    wr_n_i = 1'b1;
    addr_i = 2'h0;
    data_i = 8'h00;
    n_mismatch = 0;
    checks = 0;
    void'($urandom(32'hF93C2E37));
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(handshake_port_pkg::ADDR_PORT_C, r);
    check("reset lines", r, 8'hFF);
    check("reset drive", pc_oe_o, 8'h00);
    wr(handshake_port_pkg::ADDR_CONTROL, 8'hB4);
    check("strobed drive", pc_oe_o, 8'hEB);
    rd(handshake_port_pkg::ADDR_PORT_C, r);
    check("status cleared", r, status(2'b00, 1'b0, 1'b0, 1'b0, 1'b1));
    wr(handshake_port_pkg::ADDR_CONTROL, 8'h09);
    wr(handshake_port_pkg::ADDR_CONTROL, 8'h05);
    rd(handshake_port_pkg::ADDR_PORT_C, r);
    check("status enables", r, status(2'b00, 1'b0, 1'b1, 1'b1, 1'b1));
    wr(handshake_port_pkg::ADDR_PORT_C, 8'hFF);
    rd(handshake_port_pkg::ADDR_PORT_C, r);
    check("plain write", r, status(2'b11, 1'b0, 1'b1, 1'b1, 1'b1));
    wr(handshake_port_pkg::ADDR_CONTROL, 8'h0B);
    rd(handshake_port_pkg::ADDR_PORT_C, r);
    check("bit set full", r, status(2'b11, 1'b1, 1'b1, 1'b1, 1'b1));
    wr(handshake_port_pkg::ADDR_CONTROL, 8'h0A);
    check("bit clear full", 8'(pc_o[5]), 8'h00);
    for (i = 0; i < 6; i++) begin
      d = 8'($urandom);
      i_peripheral_model.load_a(d);
      check("input full", 8'(pc_o[5]), 8'h01);
      repeat (2) @(negedge clk_sys_i);
      check("input request", 8'(pc_o[3]), 8'h01);
      rd(handshake_port_pkg::ADDR_PORT_A, r);
      check("input latch", r, d);
      check("input full clear", 8'(pc_o[5]), 8'h00);
      d = 8'($urandom);
      wr(handshake_port_pkg::ADDR_PORT_B, d);
      check("output latch", pb_o, d);
      check("output full", 8'(pc_o[1]), 8'h00);
      check("output request", 8'(pc_o[0]), 8'h00);
      i_peripheral_model.accept_b(i % 3, ok);
      check("accept done", 8'(ok), 8'h01);
      if (ok !== 1'b1) begin
        close_out();
      end
      check("peripheral data", taken, d);
      repeat (2) @(negedge clk_sys_i);
      check("output request", 8'(pc_o[0]), 8'h01);
    end
    wr(handshake_port_pkg::ADDR_CONTROL, 8'hC0);
    rd(handshake_port_pkg::ADDR_PORT_C, r);
    check("bidir enables", r & 8'h50, 8'h00);
    check("bidir full", 8'(pc_o[7]), 8'h01);
    i_peripheral_model.pin(6, 1'b0);
    check("bidir drive on", 8'(pa_oe_o), 8'h01);
    i_peripheral_model.pin(6, 1'b1);
    check("bidir drive off", 8'(pa_oe_o), 8'h00);
    wr(handshake_port_pkg::ADDR_CONTROL, 8'h0D);
    wr(handshake_port_pkg::ADDR_CONTROL, 8'h09);
    d = 8'($urandom);
    wr(handshake_port_pkg::ADDR_PORT_A, d);
    check("bidir full low", 8'(pc_o[7]), 8'h00);
    i_peripheral_model.pin(6, 1'b0);
    check("bidir data", pa_o, d);
    i_peripheral_model.pin(6, 1'b1);
    repeat (2) @(negedge clk_sys_i);
    check("bidir full high", 8'(pc_o[7]), 8'h01);
    check("bidir request", 8'(pc_o[3]), 8'h01);
    d = 8'($urandom);
    i_peripheral_model.load_a(d);
    rd(handshake_port_pkg::ADDR_PORT_A, r);
    check("bidir input", r, d);
    close_out();
  end
endmodule

bind strobed_handshake_port strobed_handshake_port_chk i_strobed_handshake_port_chk (.clk_sys_i,
  .rst_n_i, .cs_n_i, .rd_n_i, .wr_n_i, .addr_i, .data_i, .data_oe_o, .pa_oe_o, .pb_oe_o, .pc_i,
  .pc_o, .pc_oe_o);
